/* logic/hlt_timer.sv */
// Purpose: 8-bit period timer with hardware limit modes behind an AXI4-Lite slave
// Assumes: EXTERNAL_RESET_SIGNAL is synchronous to CLK; timer clock is CLK via prescaler
// Notes:   CE low freezes every flip-flop, bus side included
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - software gate: count while enabled, hold otherwise, wrap to zero after match
// - mode 00001 counts while signal high, 00010 while low
// - modes 00011/00100/00101 reset count on any, rising or falling edge
// - after an edge reset, counting resumes from zero two clocks later
// - mode 00110 holds reset while signal low, 00111 while high
// - level limit modes ignore the external signal while enable is clear
// - level reset acts two clocks after level, restart two clocks after release
// - mode 01000 runs one period, then hardware clears enable and waits
// - software one-shot pauses on enable clear, fresh cycle only after match
// - modes 01001/01010/01011 start on rising, falling or any edge, clear enable
// - edge one-shot halted by enable clear needs a new edge to resume
// - modes 01100/01101 start on first edge, later edges reset with two-clock hold
// - edge limit one-shot ignores edges until enable set, match clears enable
// - one-shot: clock after match clears enable and stops count at zero
// - monostable: clock after match stops count at zero, enable stays set
// - edge-started modes need a fresh edge after enable was clear
// - level one-shot starts with enable and active level, reset level holds zero
// - postscaled event when postscale count reaches the selected ratio 1:1 to 1:16
// - interrupt request passes only while the interrupt enable bit is set
// - enable and external signal pass a two-stage synchroniser before use
// - monostable 10001/10010/10011 start on edge, stop incrementing at match
// - prescaler and postscaler clear on count or control write and reset events
module hlt_timer
  import hlt_timer_pkg::*;
(
  // clock, reset, freeze
  input  wire logic                      CLK,
  input  wire logic                      NRST,
  input  wire logic                      CE,
  // AXI4-Lite write
  input  wire logic [hlt_timer_pkg::ADDR_W-1:0] AWADDR,
  input  wire logic                      AWVALID,
  output logic                           AWREADY,
  input  wire logic [31:0]               WDATA,
  input  wire logic [3:0]                WSTRB,
  input  wire logic                      WVALID,
  output logic                           WREADY,
  output logic [1:0]                     BRESP,
  output logic                           BVALID,
  input  wire logic                      BREADY,
  // AXI4-Lite read
  input  wire logic [hlt_timer_pkg::ADDR_W-1:0] ARADDR,
  input  wire logic                      ARVALID,
  output logic                           ARREADY,
  output logic [31:0]                    RDATA,
  output logic [1:0]                     RRESP,
  output logic                           RVALID,
  input  wire logic                      RREADY,
  // timer side
  input  wire logic                      EXTERNAL_RESET_SIGNAL,
  output logic [7:0]                     TIMER_COUNT,
  output logic                           POSTSCALED,
  output logic                           TIMER_IRQ
);
  import hlt_timer_pkg::*;

  state_s            q;
  state_s            next;
  logic              en;
  logic              ers;
  logic              rise;
  logic              fall;
  logic              tick;
  logic              match;
  logic [6:0]        pre_lim;
  logic              need_start;
  logic              start_ev;
  logic              rst_ev;
  logic              lvl_rst;
  logic              gate_ok;
  logic              one_shot;
  logic              mono;
  logic              reserved;
  logic              rst_hit;
  logic              lvl_hit;
  logic              start_hit;
  logic              running;
  logic              do_wr;
  logic [ADDR_W-1:0] wa;
  logic              wr_ctrl;
  logic              wr_mode;
  logic              wr_cnt;
  logic              wr_per;
  logic              wr_irq;
  logic              wr_map;
  logic [ADDR_W-1:0] ra;
  logic [31:0]       rd_data;
  logic              rd_err;

  // synchronised controls, prescaler tick and period compare
  assign en      = q.on_d2;
  assign ers     = q.ers_s2;
  assign rise    = q.ers_s2 & ~q.ers_s3;
  assign fall    = ~q.ers_s2 & q.ers_s3;
  assign pre_lim = 7'((8'h01 << q.ps) - 8'h01);
  assign tick    = (q.pre == pre_lim);
  assign match   = (q.count == q.period);

  // mode decode
  always_comb begin
    need_start = 1'b0;
    start_ev   = 1'b0;
    rst_ev     = 1'b0;
    lvl_rst    = 1'b0;
    gate_ok    = 1'b1;
    one_shot   = 1'b0;
    mono       = 1'b0;
    reserved   = 1'b0;
    case (mode_e'(q.mode))
      M_SW_GATE: ;
      M_GATE_HI: gate_ok = ers;
      M_GATE_LO: gate_ok = ~ers;
      M_RST_ANY: rst_ev = rise | fall;
      M_RST_RISE: rst_ev = rise;
      M_RST_FALL: rst_ev = fall;
      M_RST_LOW: lvl_rst = ~ers;
      M_RST_HIGH: lvl_rst = ers;
      M_OS_SW: one_shot = 1'b1;
      M_OS_RISE, M_OS_FALL, M_OS_ANY: begin
        one_shot   = 1'b1;
        need_start = 1'b1;
        start_ev   = (q.mode[1:0] == 2'h1) ? rise : (q.mode[1:0] == 2'h2) ? fall : (rise | fall);
      end
      M_OS_RST_RISE, M_OS_RST_FALL: begin
        one_shot   = 1'b1;
        need_start = 1'b1;
        start_ev   = q.mode[0] ? fall : rise;
        rst_ev     = start_ev;
      end
      M_OS_LVL_LOW, M_OS_LVL_HIGH: begin
        one_shot   = 1'b1;
        need_start = 1'b1;
        start_ev   = q.mode[0] ? fall : rise;
        lvl_rst    = q.mode[0] ? ers : ~ers;
      end
      M_MONO_RISE, M_MONO_FALL, M_MONO_ANY: begin
        mono       = 1'b1;
        need_start = 1'b1;
        start_ev   = (q.mode[1:0] == 2'h1) ? rise : (q.mode[1:0] == 2'h2) ? fall : (rise | fall);
      end
      M_LOS_LOW, M_LOS_HIGH: begin
        one_shot = 1'b1;
        lvl_rst  = q.mode[0] ? ers : ~ers;
        gate_ok  = ~lvl_rst;
      end
      default: reserved = 1'b1;
    endcase
  end

  // events only count while enabled
  assign lvl_hit   = en & lvl_rst;
  assign rst_hit   = en & rst_ev & (!need_start || q.run != RS_IDLE);
  assign start_hit = en & need_start & (q.run == RS_IDLE) & start_ev & ~lvl_rst;
  assign running   = en & gate_ok & (need_start ? (q.run == RS_RUN) : (q.run != RS_HOLD));

  // write decode, low byte lane only
  assign do_wr   = q.aw_got & q.w_got & ~q.bvalid;
  assign wa      = {q.aw_addr[ADDR_W-1:2], 2'b00};
  assign wr_map  = (wa == OFS_CTRL) | (wa == OFS_MODE) | (wa == OFS_COUNT) | (wa == OFS_PERIOD)
                 | (wa == OFS_IRQ) | (wa == OFS_STATUS);
  assign wr_ctrl = do_wr & q.w_lane0 & (wa == OFS_CTRL);
  assign wr_mode = do_wr & q.w_lane0 & (wa == OFS_MODE);
  assign wr_cnt  = do_wr & q.w_lane0 & (wa == OFS_COUNT);
  assign wr_per  = do_wr & q.w_lane0 & (wa == OFS_PERIOD);
  assign wr_irq  = do_wr & q.w_lane0 & (wa == OFS_IRQ);

  // read mux
  assign ra = {ARADDR[ADDR_W-1:2], 2'b00};
  always_comb begin
    rd_err  = 1'b0;
    rd_data = 32'h0000_0000;
    case (ra)
      OFS_CTRL: rd_data = {24'h00_0000, q.on, q.ps, q.postsel};
      OFS_MODE: rd_data = {27'h000_0000, q.mode};
      OFS_COUNT: rd_data = {24'h00_0000, q.count};
      OFS_PERIOD: rd_data = {24'h00_0000, q.period};
      OFS_IRQ: rd_data = {30'h0000_0000, q.ie, q.flag};
      OFS_STATUS: rd_data = {29'h0000_0000, en, q.run};
      default: rd_err = 1'b1;
    endcase
  end

  // next state of the whole block
  always_comb begin
    next            = q;
    next.ers_s1     = EXTERNAL_RESET_SIGNAL;
    next.ers_s2     = q.ers_s1;
    next.ers_s3     = q.ers_s2;
    next.on_d1      = q.on;
    next.on_d2      = q.on_d1;
    next.postscaled = 1'b0;
    next.pre        = tick ? 7'h00 : q.pre + 7'h01;
    if (need_start && !en) begin
      next.run = RS_IDLE;
    end
    if (reserved) begin
      next.count = 8'h00;
      next.run   = RS_IDLE;
    end else if (lvl_hit) begin
      next.count = 8'h00;
      next.pre   = 7'h00;
      next.post  = 4'h0;
      if (need_start) begin
        next.run = RS_IDLE;
      end
    end else if (rst_hit) begin
      next.count = 8'h00;
      next.pre   = 7'h00;
      next.post  = 4'h0;
      next.run   = RS_HOLD;
      next.hold  = HOLD_TICKS;
    end else if (start_hit) begin
      next.run = RS_RUN;
    end else if (tick && en && q.run == RS_HOLD) begin
      next.hold = q.hold - 2'h1;
      if (q.hold == 2'h1) begin
        next.run = RS_RUN;
      end
    end else if (tick && running) begin
      if (match) begin
        next.count = 8'h00;
        if (q.post == q.postsel) begin
          next.postscaled = 1'b1;
          next.post       = 4'h0;
        end else begin
          next.post = q.post + 4'h1;
        end
        if (one_shot) begin
          next.on    = 1'b0;
          next.on_d1 = 1'b0;
          next.on_d2 = 1'b0;
          next.run   = RS_IDLE;
        end
        if (mono) begin
          next.run = RS_IDLE;
        end
      end else begin
        next.count = q.count + 8'h01;
      end
    end
    // software writes win over hardware updates of the same field
    if (wr_ctrl) begin
      next.on      = q.w_data[CTRL_ON_BIT];
      next.ps      = q.w_data[CTRL_PS_LSB +: 3];
      next.postsel = q.w_data[3:0];
      next.pre     = 7'h00;
      next.post    = 4'h0;
    end
    if (wr_mode) begin
      next.mode = q.w_data[4:0];
    end
    if (wr_cnt) begin
      next.count = q.w_data;
      next.pre   = 7'h00;
      next.post  = 4'h0;
    end
    if (wr_per) begin
      next.period = q.w_data;
    end
    if (wr_irq) begin
      next.ie = q.w_data[IRQ_IE_BIT];
    end
    // flag: write one clears, a pulse in the same cycle wins
    next.flag = (q.flag & ~(wr_irq & q.w_data[IRQ_FLAG_BIT])) | q.postscaled;
    next.irq  = next.flag & next.ie;
    // bus write channels
    if (AWVALID && q.awready) begin
      next.aw_got  = 1'b1;
      next.aw_addr = AWADDR;
    end
    if (WVALID && q.wready) begin
      next.w_got   = 1'b1;
      next.w_data  = WDATA[7:0];
      next.w_lane0 = WSTRB[0];
    end
    if (do_wr) begin
      next.aw_got = 1'b0;
      next.w_got  = 1'b0;
      next.bvalid = 1'b1;
      next.bresp  = wr_map ? RESP_OKAY : RESP_SLVERR;
    end else if (q.bvalid && BREADY) begin
      next.bvalid = 1'b0;
    end
    next.awready = ~next.aw_got;
    next.wready  = ~next.w_got;
    // bus read channel
    if (ARVALID && q.arready) begin
      next.rvalid = 1'b1;
      next.rdata  = rd_data;
      next.rresp  = rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (q.rvalid && RREADY) begin
      next.rvalid = 1'b0;
    end
    next.arready = ~next.rvalid;
  end

  // state register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      q        <= '0;
      q.period <= PERIOD_RST;
    end else if (CE) begin
      q <= next;
    end
  end

  // outputs straight from state flops
  assign AWREADY     = q.awready;
  assign WREADY      = q.wready;
  assign BRESP       = q.bresp;
  assign BVALID      = q.bvalid;
  assign ARREADY     = q.arready;
  assign RDATA       = q.rdata;
  assign RRESP       = q.rresp;
  assign RVALID      = q.rvalid;
  assign TIMER_COUNT = q.count;
  assign POSTSCALED  = q.postscaled;
  assign TIMER_IRQ   = q.irq;

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  a_sw_gate_step: assert property (CE && q.mode == M_SW_GATE && tick && en && !match && !wr_cnt
    |=> q.count == $past(q.count) + 8'h01) else $error("software gate count did not advance");
  a_hw_gate_hold: assert property (CE && q.mode == M_GATE_HI && !ers && !wr_cnt
    |=> $stable(q.count)) else $error("hardware gate failed to hold count");
  a_edge_restart: assert property ((CE && rst_hit && q.ps == 3'h0 && !do_wr)
    ##1 (CE && en && !rst_hit && !lvl_hit && !reserved && !do_wr) [*2] |=> q.run == RS_RUN)
    else $error("edge reset hold not two clocks");
  a_level_reset: assert property (CE && lvl_hit && !wr_cnt |=> q.count == 8'h00)
    else $error("level reset did not clear count");
  a_level_ignore: assert property (CE && !en && q.mode inside {M_RST_LOW, M_RST_HIGH} && !wr_cnt
    |=> $stable(q.count)) else $error("external level acted while disabled");
  a_oneshot_end: assert property (CE && one_shot && tick && running && match && !lvl_hit && !do_wr
    |=> !q.on && !q.on_d2 && q.count == 8'h00 && q.run == RS_IDLE) else $error("one-shot did not stop");
  a_mono_end: assert property (CE && mono && tick && running && match && !do_wr
    |=> q.on && q.count == 8'h00 && q.run == RS_IDLE) else $error("monostable did not stop with enable set");
  a_need_edge: assert property (CE && need_start && !en |=> q.run == RS_IDLE)
    else $error("edge start armed while disabled");
  a_post_ratio: assert property (CE && tick && running && match && !lvl_hit && !do_wr
    && q.post == q.postsel |=> q.postscaled && q.post == 4'h0) else $error("postscaled pulse missing");
  a_irq_gate: assert property (CE && q.postscaled && q.ie && !wr_irq |=> q.flag && q.irq)
    else $error("interrupt not raised");
  a_on_sync: assert property (CE && q.on && !q.on_d1 |=> !q.on_d2)
    else $error("enable used before two sync stages");
  a_scale_clear: assert property (CE && wr_ctrl |=> q.pre == 7'h00 && q.post == 4'h0)
    else $error("prescaler not cleared by control write");
  a_reserved_zero: assert property (CE && reserved && !wr_cnt |=> q.count == 8'h00)
    else $error("reserved mode counted");

  c_oneshot_done: cover property (CE && one_shot && tick && running && match);
  c_edge_reset: cover property (CE && rst_hit && q.run == RS_RUN);
  c_mono_restart: cover property (CE && mono && start_hit);
  c_post_pulse: cover property (q.postscaled && q.ie);
endmodule // hlt_timer
`default_nettype wire

/* logic/hlt_timer_pkg.sv */
// Purpose: constants, modes and state layout of the hardware limit period timer
// Assumes: registers are 8 bits wide, one aligned 32-bit word each
// Notes:   byte offsets of the register map are local choices
package hlt_timer_pkg;
  localparam int ADDR_W = 8;
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MODE   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
  // field positions
  localparam int CTRL_ON_BIT = 7;
  localparam int CTRL_PS_LSB = 4;
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_IE_BIT = 1;
  // reset values and counts
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [1:0] HOLD_TICKS = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // operating modes
  typedef enum logic [4:0] {
    M_SW_GATE = 5'h00, M_GATE_HI = 5'h01, M_GATE_LO = 5'h02, M_RST_ANY = 5'h03,
    M_RST_RISE = 5'h04, M_RST_FALL = 5'h05, M_RST_LOW = 5'h06, M_RST_HIGH = 5'h07,
    M_OS_SW = 5'h08, M_OS_RISE = 5'h09, M_OS_FALL = 5'h0A, M_OS_ANY = 5'h0B,
    M_OS_RST_RISE = 5'h0C, M_OS_RST_FALL = 5'h0D, M_OS_LVL_LOW = 5'h0E, M_OS_LVL_HIGH = 5'h0F,
    M_MONO_RISE = 5'h11, M_MONO_FALL = 5'h12, M_MONO_ANY = 5'h13,
    M_LOS_LOW = 5'h16, M_LOS_HIGH = 5'h17
  } mode_e;
  // run state of the start and hold sequencing
  typedef enum logic [1:0] {RS_IDLE = 2'h0, RS_RUN = 2'h1, RS_HOLD = 2'h3} run_e;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    logic aw_got; logic w_got; logic [ADDR_W-1:0] aw_addr; logic [7:0] w_data; logic w_lane0;
    logic on; logic [2:0] ps; logic [3:0] postsel; logic [4:0] mode;
    logic [7:0] count; logic [7:0] period; logic flag; logic ie; logic irq;
    logic on_d1; logic on_d2; logic ers_s1; logic ers_s2; logic ers_s3;
    logic [6:0] pre; logic [3:0] post; logic postscaled; run_e run; logic [1:0] hold;
  } state_s;
endpackage

/* verif/ers_source.sv */
// Purpose: model of the on-chip source of the external reset signal
// Assumes: the source changes its line just after a rising clock edge
// Notes:   every change is followed by six quiet clocks, enough for edge and level modes
`timescale 1ns/1ns
`default_nettype none
module ers_source (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // driven line
  output var logic  ers
);
  // line idles low and returns low on reset
  initial begin
    ers = 1'b0;
  end
  always @(negedge nrst) begin
    ers <= 1'b0;
  end
  // one change, then hold so edges stay six clocks apart and levels six long
  task automatic drive(input logic lvl);
    @(posedge clk);
    ers <= lvl;
    repeat (6) @(posedge clk);
  endtask
endmodule // ers_source
`default_nettype wire

/* verif/hw_limit_period_timer_modes_tb_top.sv */
// Purpose: self-checking bench of the hardware limit period timer
// Assumes: prescale 1:1 unless a scenario says otherwise; CE and strobes drop only where a scenario says so
// Notes:   counts are sampled on falling edges, or right after a bus access or a source drive; every wait is bounded
`timescale 1ns/1ns
`default_nettype none
module hw_limit_period_timer_modes_tb_top;
  import hlt_timer_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, cnt, rdat, v;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        ce = 1'b1;
  logic [3:0]  strb = 4'hF;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp, resp;
  logic        awready, wready, bvalid, arready, rvalid, postscaled, irq, ers;
  int          mismatches = 0, checks = 0;
  // block under test and the far-side signal source
  hlt_timer DUT (
    .CLK(clk), .NRST(nrst), .CE(ce), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(strb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
    .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .EXTERNAL_RESET_SIGNAL(ers),
    .TIMER_COUNT(cnt), .POSTSCALED(postscaled), .TIMER_IRQ(irq)
  );
  ers_source src (.clk(clk), .nrst(nrst), .ers(ers));
  // 100 ns clock
  always #50 clk = ~clk;
  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one comparison, reported at once when it fails
  task automatic ck(input bit ok, input string m);
    checks++;
    if (!ok) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic tmo(input string m);
    mismatches++;
    $display("MISMATCH %0t timeout %s", $time, m);
    complete_run();
  endtask
  // write: address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 40 && !(bvalid === 1'b1)) begin
      @(posedge clk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    resp = bresp;
    bready <= 1'b0;
    if (n >= 40) tmo("write");
  endtask
  // read: ready held until the data is sampled
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 40 && !(rvalid === 1'b1)) begin
      @(posedge clk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    rdat = rdata[7:0];
    resp = rresp;
    rready <= 1'b0;
    if (n >= 40) tmo("read");
  endtask
  task automatic wait_cnt(input logic [7:0] w);
    int n;
    n = 0;
    while (cnt !== w && n < 600) begin
      @(negedge clk);
      n++;
    end
    if (n >= 600) tmo("count");
  endtask
  task automatic pulse_wait;
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (postscaled !== 1'b1 && n < 600);
    if (n >= 600) tmo("postscaled");
  endtask
  // stop, program mode and period, zero the count, then write control
  task automatic setup(input logic [4:0] m, input logic [7:0] p, input logic [7:0] c);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_MODE, {3'h0, m});
    wr(OFS_PERIOD, p);
    wr(OFS_COUNT, 8'h00);
    wr(OFS_CTRL, c);
  endtask
  task automatic s_regs;
    rd(OFS_PERIOD);
    ck(rdat === PERIOD_RST && resp === RESP_OKAY, "period reset value");
    rd(8'h18);
    ck(resp === RESP_SLVERR && rdat === 8'h00, "unmapped read");
    wr(8'h18, 8'h5A);
    ck(resp === RESP_SLVERR, "unmapped write");
  endtask
  task automatic s_gate;
    setup(M_SW_GATE, 8'h02, 8'h80);
    @(negedge clk);
    ck(cnt === 8'h00, "enable acted early");
    wait_cnt(8'h02);
    wait_cnt(8'h00);
    @(negedge clk);
    ck(cnt === 8'h01, "no wrap to zero");
    wr(OFS_CTRL, 8'h00);
    repeat (4) @(negedge clk);
    v = cnt;
    repeat (6) @(negedge clk);
    ck(cnt === v, "count ran while disabled");
  endtask
  task automatic s_post;
    int n;
    for (int ps = 0; ps < 4; ps += 3) begin
      setup(M_SW_GATE, 8'h02, 8'(8'h80 + ps));
      pulse_wait();
      n = 0;
      pulse_wait();
      repeat (1) n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (postscaled !== 1'b1 && n < 100);
      ck(n == (ps + 1) * 3, "postscale interval");
    end
  endtask
  task automatic s_irq;
    wr(OFS_CTRL, 8'h00);
    wr(OFS_IRQ, 8'h01);
    setup(M_SW_GATE, 8'h02, 8'h80);
    pulse_wait();
    repeat (3) @(negedge clk);
    ck(irq === 1'b0, "request while masked");
    wr(OFS_CTRL, 8'h00);
    rd(OFS_IRQ);
    ck(rdat[0] === 1'b1, "flag not held");
    wr(OFS_IRQ, 8'h02);
    repeat (2) @(negedge clk);
    ck(irq === 1'b1, "request not raised");
    // a write with the low strobe clear must leave the flag alone
    @(posedge clk);
    strb <= 4'h0;
    wr(OFS_IRQ, 8'h03);
    strb <= 4'hF;
    repeat (2) @(negedge clk);
    ck(irq === 1'b1 && resp === RESP_OKAY, "write without strobe acted");
    wr(OFS_IRQ, 8'h03);
    repeat (2) @(negedge clk);
    ck(irq === 1'b0, "flag not cleared");
    // run again with the request unmasked: flag and request follow the pulse
    wr(OFS_CTRL, 8'h80);
    pulse_wait();
    ck(irq === 1'b0, "request ahead of flag");
    @(negedge clk);
    ck(irq === 1'b1, "request not raised by pulse");
    wr(OFS_CTRL, 8'h00);
  endtask
  // gate closed is low for the first code, high for the second
  task automatic s_hwgate;
    for (int k = 0; k < 2; k++) begin
      src.drive(k == 1);
      setup(5'(5'h01 + k), 8'hFF, 8'h80);
      v = cnt;
      repeat (6) @(negedge clk);
      ck(cnt === v, "count ran with gate closed");
      src.drive(k == 0);
      @(negedge clk);
      ck(cnt !== v, "count held with gate open");
    end
  endtask
  // any, rising and falling edge reset codes, each given a rise then a fall
  task automatic s_edge;
    for (int k = 0; k < 3; k++) begin
      src.drive(1'b0);
      setup(5'(5'h03 + k), 8'hFF, 8'h80);
      repeat (14) @(negedge clk);
      for (int e = 1; e >= 0; e--) begin
        v = cnt;
        src.drive(e[0]);
        @(negedge clk);
        if ((e == 1 && k != 2) || (e == 0 && k != 1)) ck(cnt < 8'h06, "edge reset missing");
        else ck(cnt > v, "spurious edge reset");
        v = cnt;
        repeat (4) @(negedge clk);
        ck(cnt > v, "no resume after reset");
      end
    end
  endtask
  task automatic s_level;
    for (int k = 0; k < 2; k++) begin
      src.drive(k == 0);
      setup(5'(5'h06 + k), 8'hFF, 8'h80);
      repeat (10) @(negedge clk);
      wr(OFS_CTRL, 8'h00);
      src.drive(k != 0);
      ck(cnt !== 8'h00, "level seen while disabled");
      wr(OFS_CTRL, 8'h80);
      repeat (6) @(negedge clk);
      ck(cnt === 8'h00, "level reset not held");
      src.drive(k == 0);
      repeat (2) @(negedge clk);
      ck(cnt !== 8'h00, "no restart after release");
    end
  endtask
  task automatic s_oneshot;
    setup(M_OS_SW, 8'h03, 8'h80);
    wait_cnt(8'h03);
    wait_cnt(8'h00);
    repeat (6) @(negedge clk);
    ck(cnt === 8'h00, "one-shot did not stop");
    rd(OFS_CTRL);
    ck(rdat[7] === 1'b0, "enable not cleared");
  endtask
  // rising edge one-shot, then rising edge monostable
  task automatic s_start;
    for (int k = 0; k < 2; k++) begin
      src.drive(1'b0);
      setup(k ? M_MONO_RISE : M_OS_RISE, 8'h04, 8'h80);
      repeat (8) @(negedge clk);
      ck(cnt === 8'h00, "started without edge");
      src.drive(1'b1);
      wait_cnt(8'h04);
      wait_cnt(8'h00);
      repeat (4) @(negedge clk);
      ck(cnt === 8'h00, "count not stopped at zero");
      rd(OFS_CTRL);
      ck(rdat[7] === k[0], "enable after match");
      src.drive(1'b0);
      src.drive(1'b1);
      @(negedge clk);
      ck((cnt !== 8'h00) == k[0], "restart by edge");
    end
  endtask
  task automatic s_reserved;
    setup(5'h10, 8'hFF, 8'h80);
    src.drive(1'b1);
    src.drive(1'b0);
    @(negedge clk);
    ck(cnt === 8'h00, "reserved code counted");
  endtask
  // prescale 1:2 rate, then a freeze by the clock enable
  task automatic s_freeze;
    setup(M_SW_GATE, 8'hFF, 8'h90);
    repeat (4) @(negedge clk);
    v = cnt;
    repeat (4) @(negedge clk);
    ck(cnt === 8'(v + 8'h02), "prescaled count rate");
    @(posedge clk);
    ce <= 1'b0;
    @(negedge clk);
    v = cnt;
    repeat (5) @(negedge clk);
    ck(cnt === v, "count ran with clock enable low");
    @(posedge clk);
    ce <= 1'b1;
    repeat (4) @(negedge clk);
    ck(cnt !== v, "count still frozen");
  endtask
  // rising then falling edge limit one-shot: idle level k, active level the inverse
  task automatic s_limit;
    for (int k = 0; k < 2; k++) begin
      src.drive(k[0]);
      setup(5'(5'h0C + k), 8'hFF, 8'h00);
      src.drive(!k[0]);
      src.drive(k[0]);
      wr(OFS_CTRL, 8'h80);
      repeat (4) @(negedge clk);
      ck(cnt === 8'h00, "edge before enable started count");
      src.drive(!k[0]);
      @(negedge clk);
      ck(cnt !== 8'h00, "edge limit did not start");
      src.drive(k[0]);
      src.drive(!k[0]);
      @(negedge clk);
      ck(cnt === 8'h01, "edge limit reset hold");
    end
  endtask
  // level one-shot, reset level low then high
  task automatic s_levos;
    for (int k = 0; k < 2; k++) begin
      src.drive(k[0]);
      setup(5'(5'h16 + k), 8'h0A, 8'h80);
      repeat (4) @(negedge clk);
      ck(cnt === 8'h00, "level one-shot ran at reset level");
      src.drive(!k[0]);
      @(negedge clk);
      ck(cnt === 8'h04, "level one-shot start timing");
      wait_cnt(8'h0A);
      wait_cnt(8'h00);
      repeat (3) @(negedge clk);
      rd(OFS_CTRL);
      ck(rdat[7] === 1'b0 && cnt === 8'h00, "level one-shot did not stop");
    end
  endtask
  // reset for twelve clocks, then every scenario in turn
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    s_regs();
    s_gate();
    s_post();
    s_irq();
    s_hwgate();
    s_edge();
    s_level();
    s_oneshot();
    s_start();
    s_reserved();
    s_freeze();
    s_limit();
    s_levos();
    complete_run();
  end
endmodule // hw_limit_period_timer_modes_tb_top
`default_nettype wire
